//--- core/efmc_pkg.sv
/*
  efmc_pkg: widths, channel indices, register offsets, field positions and
  reset values shared by both ends of the encoder freeze / marker capture.
  Assumes a single core clock and a synchronous active high reset.
*/
`default_nettype none

package efmc_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int EFMC_HALF_W = 16;
  localparam int EFMC_WORD_W = 32;
  localparam int EFMC_ADDR_W = 8;
  localparam int EFMC_N_CH   = 4;

  typedef logic [EFMC_HALF_W-1:0] efmc_half_t;
  typedef logic [EFMC_WORD_W-1:0] efmc_word_t;
  typedef logic [EFMC_ADDR_W-1:0] efmc_addr_t;
  typedef logic [EFMC_N_CH-1:0]   efmc_ch_t;

  // ****************************************************
  // channels: two freeze, two marker
  // ****************************************************
  localparam int EFMC_CH_REF_FRZ = 0;
  localparam int EFMC_CH_FB_FRZ  = 1;
  localparam int EFMC_CH_REF_MK  = 2;
  localparam int EFMC_CH_FB_MK   = 3;

  // freeze edge select values
  localparam logic EFMC_EDGE_RISE = 1'b0;
  localparam logic EFMC_EDGE_FALL = 1'b1;

  // ****************************************************
  // controller register map (byte addresses)
  // ****************************************************
  localparam efmc_addr_t EFMC_OFS_CTRL    = 8'h00;
  localparam efmc_addr_t EFMC_OFS_FLAGS   = 8'h04;
  localparam efmc_addr_t EFMC_OFS_STATUS  = 8'h08;
  localparam efmc_addr_t EFMC_OFS_MASK    = 8'h0C;
  localparam efmc_addr_t EFMC_OFS_REF_FRZ = 8'h10;
  localparam efmc_addr_t EFMC_OFS_FB_FRZ  = 8'h14;
  localparam efmc_addr_t EFMC_OFS_REF_MK  = 8'h18;
  localparam efmc_addr_t EFMC_OFS_FB_MK   = 8'h1C;

  // control fields
  localparam int EFMC_CTRL_EDGE_BIT = 0;
  localparam int EFMC_CTRL_EN_BIT   = 1;
  // status / mask: captures low nibble, missed events high nibble
  localparam int EFMC_ST_CAP_LSB  = 0;
  localparam int EFMC_ST_MISS_LSB = 4;
  localparam int EFMC_ST_W        = 8;

  // reset values
  localparam logic [1:0]  EFMC_CTRL_RST = 2'h0;
  localparam logic [7:0]  EFMC_MASK_RST = 8'h00;
  localparam efmc_word_t  EFMC_DATA_RST = 32'h0000_0000;
  // cycles after reset before pin edges count
  localparam logic [1:0]  EFMC_ARM_CYCLES = 2'h3;

endpackage

`default_nettype wire

//--- core/efmc_link_if.sv
/*
  efmc_link_if: the wires between the capture end and its controller.
  Assumes both ends run on the same core clock; no clocking here.
*/
`timescale 1ns/1ps
`default_nettype none

interface efmc_link_if;

  // capture end to controller
  efmc_pkg::efmc_ch_t             flag;
  efmc_pkg::efmc_ch_t             evt;
  efmc_pkg::efmc_ch_t             miss;
  logic [efmc_pkg::EFMC_N_CH-1:0][efmc_pkg::EFMC_WORD_W-1:0] cap_data;
  // controller to capture end
  logic                           frz_edge_sel;
  logic                           frz_en;
  efmc_pkg::efmc_ch_t             flag_clr;

  modport dev (
    output flag,
    output evt,
    output miss,
    output cap_data,
    input  frz_edge_sel,
    input  frz_en,
    input  flag_clr
  );

  modport ctl (
    input  flag,
    input  evt,
    input  miss,
    input  cap_data,
    output frz_edge_sel,
    output frz_en,
    output flag_clr
  );

endinterface

`default_nettype wire

//--- core/efmc_ctl_end.sv
/*
  efmc_ctl_end: controller end. Holds the edge select and freeze enable,
  clears flags on order, mirrors captured data and raises an interrupt.
  Assumes a simple one-cycle strobe bus master on the user side and the
  capture end on the same clock across the link.
*/
`timescale 1ns/1ps
`default_nettype none

module efmc_ctl_end (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire efmc_pkg::efmc_addr_t addr,
  input  wire efmc_pkg::efmc_word_t wr_data,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output var  efmc_pkg::efmc_word_t rd_data,
  output var  logic                 irq,
  efmc_link_if.ctl                  link
);

  function automatic logic hit(input efmc_pkg::efmc_addr_t a,
                               input efmc_pkg::efmc_addr_t ofs);
    return a == ofs;
  endfunction

  logic [1:0]                       ctrl;
  logic [efmc_pkg::EFMC_ST_W-1:0]   status;
  logic [efmc_pkg::EFMC_ST_W-1:0]   mask;
  logic [efmc_pkg::EFMC_ST_W-1:0]   next_status;
  logic [efmc_pkg::EFMC_ST_W-1:0]   next_mask;

  // ****************************************************
  // control register
  // ****************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= efmc_pkg::EFMC_CTRL_RST;
    end else if (wr_en && hit(addr, efmc_pkg::EFMC_OFS_CTRL)) begin
      ctrl <= wr_data[1:0];
    end
  end

  assign link.frz_edge_sel = ctrl[efmc_pkg::EFMC_CTRL_EDGE_BIT];
  assign link.frz_en       = ctrl[efmc_pkg::EFMC_CTRL_EN_BIT];

  // ****************************************************
  // flag clearing
  // ****************************************************
  // a zero written to a flag bit clears it, a one leaves it alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.flag_clr <= '0;
    end else if (wr_en && hit(addr, efmc_pkg::EFMC_OFS_FLAGS)) begin
      link.flag_clr <= ~wr_data[efmc_pkg::EFMC_N_CH-1:0];
    end else begin
      link.flag_clr <= '0;
    end
  end

  // ****************************************************
  // interrupt status and mask
  // ****************************************************
  // new events win over the read that clears
  always_comb begin
    next_status = status;
    if (rd_en && hit(addr, efmc_pkg::EFMC_OFS_STATUS)) begin
      next_status = '0;
    end
    next_status = next_status | {link.miss, link.evt};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // irq follows a new mask in the same cycle as the mask itself
  always_comb begin
    next_mask = mask;
    if (wr_en && hit(addr, efmc_pkg::EFMC_OFS_MASK)) begin
      next_mask = wr_data[efmc_pkg::EFMC_ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask <= efmc_pkg::EFMC_MASK_RST;
    end else begin
      mask <= next_mask;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  // ****************************************************
  // read port
  // ****************************************************
  // marker words are overwritten on each marker; read them promptly
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= efmc_pkg::EFMC_DATA_RST;
    end else if (rd_en) begin
      unique case (addr)
        efmc_pkg::EFMC_OFS_CTRL:    rd_data <= {30'h0, ctrl};
        efmc_pkg::EFMC_OFS_FLAGS:   rd_data <= {28'h0, link.flag};
        efmc_pkg::EFMC_OFS_STATUS:  rd_data <= {24'h0, status};
        efmc_pkg::EFMC_OFS_MASK:    rd_data <= {24'h0, mask};
        efmc_pkg::EFMC_OFS_REF_FRZ: rd_data <= link.cap_data[efmc_pkg::EFMC_CH_REF_FRZ];
        efmc_pkg::EFMC_OFS_FB_FRZ:  rd_data <= link.cap_data[efmc_pkg::EFMC_CH_FB_FRZ];
        efmc_pkg::EFMC_OFS_REF_MK:  rd_data <= link.cap_data[efmc_pkg::EFMC_CH_REF_MK];
        efmc_pkg::EFMC_OFS_FB_MK:   rd_data <= link.cap_data[efmc_pkg::EFMC_CH_FB_MK];
        default:                    rd_data <= efmc_pkg::EFMC_DATA_RST;
      endcase
    end else begin
      rd_data <= efmc_pkg::EFMC_DATA_RST;
    end
  end

endmodule // efmc_ctl_end

`default_nettype wire

//--- core/efmc_dev_end.sv
/*
  efmc_dev_end: capture end. Freezes revolution count and position of the
  reference and feedback encoder counters on a freeze pulse from a
  neighbouring module, and caches each encoder's pair again on its own marker.
  Assumes the counter values are on core_clk; the freeze and marker pulses
  are asynchronous pins. The controller sits across efmc_link_if.
  Pins should idle low through reset: the sync stages start at 0, and
  edges are ignored until each stage holds a real sample of its pin.
  Freeze and marker pulses need one cycle high and one low to be seen.
  Counter values must be steady in the cycle that an edge is taken.

*/
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module efmc_dev_end (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 frz_pulse,
  input  wire logic                 ref_marker,
  input  wire logic                 fb_marker,
  input  wire efmc_pkg::efmc_half_t ref_rev,
  input  wire efmc_pkg::efmc_half_t ref_pos,
  input  wire efmc_pkg::efmc_half_t fb_rev,
  input  wire efmc_pkg::efmc_half_t fb_pos,
  efmc_link_if.dev                  link
);

  // ****************************************************
  // decode helpers
  // ****************************************************
  // edge of a synchronised level, direction chosen by fall
  function automatic logic edge_hit(input logic cur,
                                    input logic prev,
                                    input logic fall);
    return fall ? (prev & ~cur) : (cur & ~prev);
  endfunction

  // counter pair as one word: revolutions high, position low
  function automatic efmc_pkg::efmc_word_t pack_word(input efmc_pkg::efmc_half_t rev,
                                                     input efmc_pkg::efmc_half_t pos);
    return {rev, pos};
  endfunction

  // ****************************************************
  // synchronisers
  // ****************************************************
  // stage 0 feeds stage 1 only; stage 2 is the previous stage 1
  logic [2:0]                       frz_sync;
  logic [2:0]                       ref_mk_sync;
  logic [2:0]                       fb_mk_sync;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frz_sync <= 3'h0;
    end else begin
      frz_sync <= {frz_sync[1:0], frz_pulse};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_mk_sync <= 3'h0;
    end else begin
      ref_mk_sync <= {ref_mk_sync[1:0], ref_marker};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fb_mk_sync <= 3'h0;
    end else begin
      fb_mk_sync <= {fb_mk_sync[1:0], fb_marker};
    end
  end

  // ****************************************************
  // arming after reset
  // ****************************************************
  // stages start at 0 whatever the pins show, so edges
  // wait until stage 2 holds a real sample of each pin
  logic [1:0]                       arm_cnt;
  logic                             armed;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arm_cnt <= 2'h0;
    end else if (!armed) begin
      arm_cnt <= arm_cnt + 2'h1;
    end
  end

  assign armed = (arm_cnt == efmc_pkg::EFMC_ARM_CYCLES);

  // ****************************************************
  // edges and triggers
  // ****************************************************
  logic                             frz_edge;
  logic                             ref_mk_edge;
  logic                             fb_mk_edge;
  efmc_pkg::efmc_ch_t               trig;
  efmc_pkg::efmc_ch_t               hold;
  efmc_pkg::efmc_ch_t               take;
  logic [efmc_pkg::EFMC_N_CH-1:0][efmc_pkg::EFMC_WORD_W-1:0] src;

  // freeze edge direction follows the select setting
  assign frz_edge    = edge_hit(frz_sync[1], frz_sync[2],
                                link.frz_edge_sel);
  // markers count on rising edges only
  assign ref_mk_edge = edge_hit(ref_mk_sync[1], ref_mk_sync[2],
                                efmc_pkg::EFMC_EDGE_RISE);
  assign fb_mk_edge  = edge_hit(fb_mk_sync[1], fb_mk_sync[2],
                                efmc_pkg::EFMC_EDGE_RISE);

  // one freeze edge drives both freeze channels, gated by enable
  always_comb begin
    trig = '0;
    trig[efmc_pkg::EFMC_CH_REF_FRZ] = frz_edge & link.frz_en & armed;
    trig[efmc_pkg::EFMC_CH_FB_FRZ]  = frz_edge & link.frz_en & armed;
    trig[efmc_pkg::EFMC_CH_REF_MK]  = ref_mk_edge & armed;
    trig[efmc_pkg::EFMC_CH_FB_MK]   = fb_mk_edge & armed;
  end

  // a flag being cleared this cycle no longer holds, so the edge is kept
  always_comb begin
    hold = '0;
    hold[efmc_pkg::EFMC_CH_REF_FRZ] = link.flag[efmc_pkg::EFMC_CH_REF_FRZ]
                                    & ~link.flag_clr[efmc_pkg::EFMC_CH_REF_FRZ];
    hold[efmc_pkg::EFMC_CH_FB_FRZ]  = link.flag[efmc_pkg::EFMC_CH_FB_FRZ]
                                    & ~link.flag_clr[efmc_pkg::EFMC_CH_FB_FRZ];
  end

  assign take = trig & ~hold;

  // ****************************************************
  // capture sources
  // ****************************************************
  // counters sampled in the edge cycle: rev high half, position low half
  assign src[efmc_pkg::EFMC_CH_REF_FRZ] = pack_word(ref_rev, ref_pos);
  assign src[efmc_pkg::EFMC_CH_FB_FRZ]  = pack_word(fb_rev, fb_pos);
  assign src[efmc_pkg::EFMC_CH_REF_MK]  = pack_word(ref_rev, ref_pos);
  assign src[efmc_pkg::EFMC_CH_FB_MK]   = pack_word(fb_rev, fb_pos);

  // ****************************************************
  // capture channels
  // ****************************************************
  genvar ch;
  generate
    for (ch = 0; ch < efmc_pkg::EFMC_N_CH; ch = ch + 1) begin : g_ch

      // whole word loaded at once, never half old and half new
      always_ff @(posedge core_clk) begin
        if (rst) begin
          link.cap_data[ch] <= efmc_pkg::EFMC_DATA_RST;
        end else if (take[ch]) begin
          link.cap_data[ch] <= src[ch];
        end
      end

      // set wins over clear
      always_ff @(posedge core_clk) begin
        if (rst) begin
          link.flag[ch] <= 1'b0;
        end else if (take[ch]) begin
          link.flag[ch] <= 1'b1;
        end else if (link.flag_clr[ch]) begin
          link.flag[ch] <= 1'b0;
        end
      end

      // one-cycle pulse, lands with the flag and the data
      always_ff @(posedge core_clk) begin
        if (rst) begin
          link.evt[ch] <= 1'b0;
        end else begin
          link.evt[ch] <= take[ch];
        end
      end

      // freeze: edge dropped by a held flag; marker: unread data lost
      always_ff @(posedge core_clk) begin
        if (rst) begin
          link.miss[ch] <= 1'b0;
        end else begin
          link.miss[ch] <= trig[ch] & link.flag[ch]
                         & ~link.flag_clr[ch];
        end
      end

    end
  endgenerate

endmodule // efmc_dev_end

`default_nettype wire

//--- test/efmc_props.sv
/*
  efmc_props: link assertions for the freeze / marker capture.
  assumes one core clock and a sync active high rst beside the link.
*/
`timescale 1ns/1ps
`default_nettype none

module efmc_props (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire efmc_pkg::efmc_ch_t flag,
  input wire efmc_pkg::efmc_ch_t evt,
  input wire efmc_pkg::efmc_ch_t miss,
  input wire logic [efmc_pkg::EFMC_N_CH-1:0][efmc_pkg::EFMC_WORD_W-1:0] cap_data,
  input wire logic               frz_edge_sel,
  input wire logic               frz_en,
  input wire efmc_pkg::efmc_ch_t flag_clr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****************************************************
  // per channel
  // ****************************************************
  for (genvar i = 0; i < 4; i++) begin : g_ch
    a_evt_flag:
      assert property (evt[i] |-> flag[i]) else $error("evt without flag");
    a_flag_rise_evt:
      assert property ($rose(flag[i]) |-> evt[i]) else $error("flag rose, no evt");
    a_flag_fall_clr:
      assert property ($fell(flag[i]) |-> $past(flag_clr[i])) else $error("flag fell alone");
    a_data_evt:
      assert property (!$stable(cap_data[i]) |-> evt[i]) else $error("data moved, no evt");
    a_miss_flag:
      assert property (miss[i] |-> $past(flag[i])) else $error("miss without flag");
    a_evt_single:
      assert property (evt[i] |=> !evt[i]) else $error("evt too long");
  end

  // ****************************************************
  // freeze channels, plus a marker flag clear cover
  // ****************************************************
  a_ref_frz_en:
    assert property (!$stable(cap_data[0]) |-> $past(frz_en)) else $error("ref frozen off");
  a_fb_frz_en:
    assert property (!$stable(cap_data[1]) |-> $past(frz_en)) else $error("fb frozen off");
  a_frz_no_miss:
    assert property (!(|(evt[1:0] & miss[1:0]))) else $error("freeze evt and miss");

  c_both_frz: cover property (evt[0] && evt[1]);
  c_fall_frz: cover property (evt[0] && frz_edge_sel);
  c_frz_miss: cover property (miss[0]);
  c_mk_clr:   cover property (flag_clr[2]);
endmodule // efmc_props

`default_nettype wire

//--- test/tb.sv
/*
  tb: drives pins, counters and the register port, checks by reads and by the irq pin.
  assumes the two ends joined by efmc_link_if on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                 core_clk = 1'b0;
  logic                 rst      = 1'b1;
  efmc_pkg::efmc_addr_t addr     = 8'h00;
  efmc_pkg::efmc_word_t wr_data  = 32'h0;
  logic                 wr_en    = 1'b0;
  logic                 rd_en    = 1'b0;
  efmc_pkg::efmc_word_t rd_data;
  logic                 irq;
  logic [2:0]           pins     = 3'h0;
  logic [15:0]          cnt [4]  = '{16'h0, 16'h0, 16'h0, 16'h0};
  int                   bad_count   = 0;
  int                   comparisons = 0;

  efmc_link_if efmc_link_if_i ();
  efmc_dev_end efmc_dev_end_i (.core_clk(core_clk), .rst(rst), .frz_pulse(pins[0]),
    .ref_marker(pins[1]), .fb_marker(pins[2]), .ref_rev(cnt[0]), .ref_pos(cnt[1]),
    .fb_rev(cnt[2]), .fb_pos(cnt[3]), .link(efmc_link_if_i.dev));
  efmc_ctl_end efmc_ctl_end_i (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .link(efmc_link_if_i.ctl));
  efmc_props efmc_props_i (.core_clk(core_clk), .rst(rst), .flag(efmc_link_if_i.flag),
    .evt(efmc_link_if_i.evt), .miss(efmc_link_if_i.miss),
    .cap_data(efmc_link_if_i.cap_data), .frz_edge_sel(efmc_link_if_i.frz_edge_sel),
    .frz_en(efmc_link_if_i.frz_en), .flag_clr(efmc_link_if_i.flag_clr));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk(input string nm, input efmc_pkg::efmc_word_t e,
                     input efmc_pkg::efmc_word_t g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge core_clk);
    comparisons++;
    if (irq !== e) begin
      bad_count++;
      $display("[FAIL] irq expected %b seen %b", e, irq);
    end
  endtask

  task automatic wr(input efmc_pkg::efmc_addr_t a, input efmc_pkg::efmc_word_t d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input efmc_pkg::efmc_addr_t a, input efmc_pkg::efmc_word_t e);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("reg %h", a), e, rd_data);
  endtask

  // 6 cycles covers 2 sync stages, capture and status
  task automatic pin(input int i, input logic v);
    @(posedge core_clk);
    pins[i] <= v;
    repeat (6) @(posedge core_clk);
  endtask

  // counters held still around each capture
  task automatic setc(input logic [15:0] b);
    @(posedge core_clk);
    for (int k = 0; k < 4; k++) begin
      cnt[k] <= b + 16'(k);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
    $display("test reset done");
    pin(0, 1'b1);
    pin(0, 1'b0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    $display("test disabled done");
    wr(8'h00, 32'h2);
    wr(8'h0C, 32'hFF);
    setc(16'h1111);
    pin(0, 1'b1);
    chk_irq(1'b1);
    rd(8'h04, 32'h3);
    rd(8'h10, 32'h1111_1112);
    rd(8'h14, 32'h1113_1114);
    rd(8'h08, 32'h03);
    chk_irq(1'b0);
    $display("test rising freeze done");
    setc(16'h2222);
    pin(0, 1'b0);
    pin(0, 1'b1);
    rd(8'h10, 32'h1111_1112);
    rd(8'h14, 32'h1113_1114);
    chk_irq(1'b1);
    rd(8'h08, 32'h30);
    wr(8'h04, 32'hC);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    rd(8'h00, 32'h3);
    setc(16'h3333);
    pin(0, 1'b0);
    rd(8'h10, 32'h3333_3334);
    rd(8'h14, 32'h3335_3336);
    rd(8'h08, 32'h03);
    wr(8'h04, 32'hC);
    pin(0, 1'b1);
    rd(8'h04, 32'h0);
    $display("test hold and falling done");
    setc(16'h4444);
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(8'h18, 32'h4444_4445);
    rd(8'h04, 32'h4);
    setc(16'h5555);
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(8'h18, 32'h5555_5556);
    rd(8'h08, 32'h44);
    wr(8'h0C, 32'h0);
    rd(8'h0C, 32'h0);
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk_irq(1'b0);
    rd(8'h1C, 32'h5557_5558);
    rd(8'h04, 32'hC);
    rd(8'h08, 32'h08);
    wr(8'h04, 32'h8);
    rd(8'h04, 32'h8);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h0);
    $display("test markers done");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
endmodule // tb

`default_nettype wire
